//--- core/counter_pkg.sv
// constants, field layouts and types for one event / frequency counter channel
// assumes a 40 MHz master clock; widths and times are fixed here
package counter_pkg;
  // timing
  localparam int CLK_NS    = 25;
  localparam int PULSE_NS  = 1600;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEB_NS    = 2400;
  // pulses of DEB_NS or shorter are rejected, so acceptance needs one cycle more
  localparam int DEB_CYC   = DEB_NS / CLK_NS + 1;

  // write port offsets
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_TRIG     = 8'h1c;
  localparam logic [7:0] OFS_TRIG_EVT = 8'h34;
  localparam logic [7:0] OFS_CONST_A  = 8'h40;
  localparam logic [7:0] OFS_CTRL     = 8'h44;
  localparam int         STAT_CH_BIT  = 0;

  // field codes
  localparam logic [2:0]  MODE_WDOG   = 3'h3;
  localparam logic [2:0]  MODE_EVT    = 3'h4;
  localparam logic [2:0]  SRC_EVT     = 3'h0;
  localparam logic [2:0]  SRC_EXT     = 3'h5;
  localparam logic [2:0]  SRC_FREQ    = 3'h7;
  localparam logic [1:0]  POL_LOW     = 2'h1;
  localparam logic [1:0]  POL_HIGH    = 2'h2;
  localparam logic [1:0]  TRIG_AUX    = 2'h3;
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [31:0] MASK16      = 32'h0000ffff;
  localparam logic [31:0] MASK32      = 32'hffffffff;

  // control word, bit 15 down to bit 0
  typedef struct packed {
    logic       irq_en;
    logic       wide;
    logic       debounce;
    logic [2:0] clk_src;
    logic [1:0] trig_sel;
    logic [1:0] evt_sel;
    logic [1:0] gate_sel;
    logic       out_pol;
    logic [2:0] mode;
  } ctrl_t;

  // field inputs: gate/enable, event/signal, trigger or up/down
  typedef struct packed {
    logic gate;
    logic evt;
    logic aux;
  } field_in_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } state_t;
endpackage

//--- core/event_freq_counter.sv
// one multifunction counter channel: event counting, frequency measurement, watchdog timing
// assumes field inputs are asynchronous pins and the write port is on i_mclk
`timescale 1ns/1ps
module event_freq_counter
  import counter_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // register write port
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_int_global,
  // field inputs
  input  wire logic        i_gate_enable_input,
  input  wire logic        i_event_signal_input,
  input  wire logic        i_aux_input,
  // outputs
  output logic             o_out_pin,
  output logic             o_irq,
  output logic [31:0]      o_count,
  output ctrl_t            o_ctrl
);

  // terminal count of the prescaler for each internal rate
  function automatic logic [4:0] div_term(input logic [2:0] src);
    case (src)
      3'h0:    div_term = 5'h1f;
      3'h1:    div_term = 5'h0f;
      3'h2:    div_term = 5'h07;
      3'h3:    div_term = 5'h03;
      default: div_term = 5'h01;
    endcase
  endfunction

  // edge of a filtered input toward the level chosen by a polarity code
  function automatic logic pol_edge(input logic [1:0] sel, input logic prev, input logic cur);
    if (sel == POL_LOW) begin
      pol_edge = prev & ~cur;
    end else if (sel == POL_HIGH) begin
      pol_edge = ~prev & cur;
    end else begin
      pol_edge = 1'b0;
    end
  endfunction

  // input synchronising and filtering
  field_in_t  sync1_q;
  field_in_t  sync2_q;
  logic [2:0] flt_q;
  logic [2:0] flt_d;
  logic [6:0] fcnt_q [3];
  logic [6:0] fcnt_d [3];
  logic [2:0] prev_q;
  logic [2:0] raw;

  // channel state
  ctrl_t       ctrl_q;
  ctrl_t       ctrl_d;
  logic [31:0] const_a_q;
  logic [31:0] const_a_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  state_t      st_q;
  state_t      st_d;
  logic [6:0]  pcnt_q;
  logic [6:0]  pcnt_d;
  logic [4:0]  pre_q;
  logic [4:0]  pre_d;
  logic        irq_q;
  logic        irq_d;
  logic        out_q;
  logic        out_d;

  // combinational helpers
  logic        is_evt;
  logic        is_freq;
  logic        is_wdog;
  logic        sw_trig;
  logic        ext_trig;
  logic        gate_ok;
  logic        en_act;
  logic        evt_edge;
  logic        tick;
  logic        fire;
  logic        irq_set;
  logic        irq_clr;
  logic [31:0] mask;
  logic [31:0] inc;

  assign raw = {sync2_q.gate, sync2_q.evt, sync2_q.aux};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fcnt_d[i] = 7'h00;
      flt_d[i]  = flt_q[i];
      if (!ctrl_q.debounce) begin
        flt_d[i] = raw[i];
      end else if (raw[i] != flt_q[i]) begin
        // a level must hold past the reject window before it is believed
        if (fcnt_q[i] == 7'(DEB_CYC - 1)) begin
          flt_d[i] = raw[i];
        end else begin
          fcnt_d[i] = fcnt_q[i] + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      flt_q   <= 3'h0;
      prev_q  <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        fcnt_q[i] <= 7'h00;
      end
    end else begin
      sync1_q <= {i_gate_enable_input, i_event_signal_input, i_aux_input};
      sync2_q <= sync1_q;
      flt_q   <= flt_d;
      prev_q  <= flt_q;
      for (int i = 0; i < 3; i++) begin
        fcnt_q[i] <= fcnt_d[i];
      end
    end
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    const_a_d = const_a_q;
    cnt_d     = cnt_q;
    st_d      = st_q;
    pre_d     = pre_q;
    irq_d     = irq_q;
    fire      = 1'b0;
    is_evt    = (ctrl_q.mode == MODE_EVT) && (ctrl_q.clk_src == SRC_EVT);
    is_freq   = (ctrl_q.mode == MODE_EVT) && (ctrl_q.clk_src == SRC_FREQ);
    is_wdog   = (ctrl_q.mode == MODE_WDOG);
    mask      = ctrl_q.wide ? MASK32 : MASK16;
    inc       = (cnt_q + 32'h1) & mask;
    // the event trigger answers at its own offset, the others at the common one
    sw_trig   = i_wr && ((is_evt && i_wr_addr == OFS_TRIG_EVT) ||
                         (!is_evt && i_wr_addr == OFS_TRIG));
    ext_trig  = pol_edge(ctrl_q.trig_sel, prev_q[0], flt_q[0]);
    evt_edge  = pol_edge(ctrl_q.evt_sel, prev_q[1], flt_q[1]);
    gate_ok   = (ctrl_q.gate_sel == POL_LOW)  ? ~flt_q[2] :
                (ctrl_q.gate_sel == POL_HIGH) ?  flt_q[2] : 1'b1;
    en_act    = (ctrl_q.gate_sel == POL_LOW)  ? ~flt_q[2] :
                (ctrl_q.gate_sel == POL_HIGH) ?  flt_q[2] : 1'b0;
    // watchdog timebase: prescaled master clock or external event edges
    tick      = 1'b0;
    if (ctrl_q.clk_src == SRC_EXT) begin
      tick = evt_edge;
    end else if (pre_q == div_term(ctrl_q.clk_src)) begin
      tick  = 1'b1;
      pre_d = 5'h00;
    end else begin
      pre_d = pre_q + 5'h01;
    end

    case (st_q)
      ST_IDLE: begin
        if (sw_trig || ext_trig) begin
          if (is_evt) begin
            cnt_d = 32'h0;
            st_d  = ST_RUN;
          end else if (is_freq) begin
            st_d = ST_ARMED;
          end else if (is_wdog) begin
            st_d = ST_RUN;
          end
        end
      end
      ST_ARMED: begin
        if (!is_freq) begin
          st_d = ST_IDLE;
        end else if (pol_edge(ctrl_q.gate_sel, prev_q[2], flt_q[2])) begin
          cnt_d = 32'h0;
          st_d  = ST_RUN;
        end
      end
      ST_RUN: begin
        if (is_evt) begin
          // keeps wrapping at the limit until a control write changes the mode or clock source field
          if (evt_edge && gate_ok) begin
            if (ctrl_q.trig_sel == TRIG_AUX && flt_q[0]) begin
              if (cnt_q != 32'h0) begin
                cnt_d = cnt_q - 32'h1;
              end
            end else if (inc == (const_a_q & mask)) begin
              // a zero limit is reached only when the count wraps past the top of the mask, so software keeps it nonzero
              cnt_d = 32'h0;
              fire  = 1'b1;
            end else begin
              cnt_d = inc;
            end
          end
        end else if (is_freq) begin
          if (!en_act) begin
            fire = 1'b1;
            st_d = ST_IDLE;
          end else if (evt_edge) begin
            cnt_d = inc;
          end
        end else if (is_wdog) begin
          if (cnt_q == 32'h0) begin
            fire = 1'b1;
            st_d = ST_IDLE;
          end else if (tick && (ctrl_q.trig_sel != TRIG_AUX || flt_q[0])) begin
            cnt_d = (cnt_q - 32'h1) & mask;
          end
        end else begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase

    if (i_wr && i_wr_addr == OFS_CTRL) begin
      ctrl_d = ctrl_t'(i_wr_data[15:0]);
      if (ctrl_d.mode != ctrl_q.mode || ctrl_d.clk_src != ctrl_q.clk_src) begin
        st_d = ST_IDLE;
      end
    end
    if (i_wr && i_wr_addr == OFS_CONST_A) begin
      const_a_d = i_wr_data;
      cnt_d     = i_wr_data & mask;
    end

    // set beats a clear arriving in the same cycle
    irq_set = fire && ctrl_q.irq_en && i_int_global;
    irq_clr = (i_wr && i_wr_addr == OFS_STATUS && i_wr_data[STAT_CH_BIT]) || !ctrl_d.irq_en;
    if (irq_set) begin
      irq_d = 1'b1;
    end else if (irq_clr) begin
      irq_d = 1'b0;
    end

    pcnt_d = fire ? 7'(PULSE_CYC) : (pcnt_q != 7'h00) ? pcnt_q - 7'h01 : 7'h00;
    // the pin rests inactive; a running watchdog also holds it active
    if (pcnt_d != 7'h00 || (is_wdog && st_d == ST_RUN)) begin
      out_d = ctrl_d.out_pol;
    end else begin
      out_d = ~ctrl_d.out_pol;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q    <= ctrl_t'(CTRL_RESET);
      const_a_q <= 32'h0;
      cnt_q     <= 32'h0;
      st_q      <= ST_IDLE;
      pcnt_q    <= 7'h00;
      pre_q     <= 5'h00;
      irq_q     <= 1'b0;
      out_q     <= 1'b1;
    end else begin
      ctrl_q    <= ctrl_d;
      const_a_q <= const_a_d;
      cnt_q     <= cnt_d;
      st_q      <= st_d;
      pcnt_q    <= pcnt_d;
      pre_q     <= pre_d;
      irq_q     <= irq_d;
      out_q     <= out_d;
    end
  end

  // readback is a plain copy, so reading never disturbs the count
  assign o_count   = cnt_q;
  assign o_ctrl    = ctrl_q;
  assign o_irq     = irq_q;
  assign o_out_pin = out_q;

endmodule

//--- testbench/event_freq_counter_monitor.sv
// port checker for the event / frequency counter channel
// assumes it is bound to the channel top from the testbench
`timescale 1ns/1ps
module event_freq_counter_monitor
  import counter_pkg::*;
(
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_reset,
  // write port
  input wire logic        i_wr,
  input wire logic [7:0]  i_wr_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic        i_int_global,
  // field pins
  input wire logic        i_gate_enable_input,
  input wire logic        i_event_signal_input,
  input wire logic        i_aux_input,
  // outputs
  input wire logic        o_out_pin,
  input wire logic        o_irq,
  input wire logic [31:0] o_count,
  input wire ctrl_t       o_ctrl
);
  logic       act;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  // run length of the active pin level; short runs come from mode changes
  assign act = (o_out_pin == o_ctrl.out_pol) && (o_ctrl.mode == MODE_EVT);
  always_comb cnt_d = act ? cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge i_mclk) cnt_q <= i_reset ? 8'h00 : cnt_d;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_reset_state:
  assert property ($fell(i_reset) |-> o_out_pin && !o_irq && o_count == 32'h0 && o_ctrl == CTRL_RESET)
    else $error("reset state wrong");
  a_ctrl_write:
  assert property (i_wr && i_wr_addr == OFS_CTRL |=> o_ctrl == $past(i_wr_data[15:0]))
    else $error("control write lost");
  a_const_load:
  assert property (i_wr && i_wr_addr == OFS_CONST_A |=> o_count[15:0] == $past(i_wr_data[15:0]))
    else $error("constant not loaded into count");
  a_evt_step:
  assert property (o_ctrl.mode == MODE_EVT && o_ctrl.clk_src == SRC_EVT && !i_wr |=>
    o_count == $past(o_count) || o_count == $past(o_count) + 32'h1 || o_count == 32'h0 ||
    (o_ctrl.trig_sel == TRIG_AUX && $past(o_count) != 32'h0 && o_count == $past(o_count) - 32'h1))
    else $error("event count step wrong");
  a_irq_cause:
  assert property ($rose(o_irq) |-> $past(o_ctrl.irq_en) && $past(i_int_global))
    else $error("interrupt without enable");
  a_irq_hold:
  assert property (o_irq && !(i_wr && (i_wr_addr == OFS_STATUS || i_wr_addr == OFS_CTRL)) |=> o_irq)
    else $error("interrupt dropped");
  a_irq_clear:
  assert property (i_wr && i_wr_addr == OFS_CTRL && !i_wr_data[15] |=> !o_irq)
    else $error("interrupt not cleared by enable bit");
  a_pulse_len:
  assert property ($fell(act) && cnt_q > 8'h02 |-> cnt_q == 8'(PULSE_CYC))
    else $error("output pulse length wrong");
  a_pulse_max:
  assert property (cnt_q <= 8'(PULSE_CYC))
    else $error("output pulse too long");
endmodule

//--- testbench/field_model.sv
// far-side model: gate, event and aux field pins
// assumes the bench clock; pins change 1 ns after a rising edge
`timescale 1ns/1ps
module field_model
  import counter_pkg::*;
(
  input  wire logic i_mclk,
  output field_in_t o_field
);
  initial o_field = '0;
  task automatic lvl(input logic g, input logic a);
    @(posedge i_mclk);
    #1;
    o_field.gate = g;
    o_field.aux  = a;
  endtask
  // high phases of w cycles, low phases of w + 1; w >= 4 keeps each phase at or above the 100 ns minimum
  task automatic evt(input int n, input int w);
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      o_field.evt = 1'b1;
      repeat (w) @(posedge i_mclk);
      #1;
      o_field.evt = 1'b0;
      repeat (w) @(posedge i_mclk);
    end
  endtask
endmodule

//--- testbench/tb_event_and_frequency_counter.sv
// self-checking bench for the event / frequency counter channel
// assumes the field model drives the pins; writes go through wr()
`timescale 1ns/1ps
module tb_event_and_frequency_counter;
  import counter_pkg::*;
  logic        i_mclk;
  logic        i_reset;
  logic        i_wr;
  logic [7:0]  i_wr_addr;
  logic [31:0] i_wr_data;
  logic        i_int_global;
  field_in_t   fld;
  logic        o_out_pin;
  logic        o_irq;
  logic [31:0] o_count;
  ctrl_t       o_ctrl;
  logic [31:0] seed;
  logic [31:0] lim;
  logic [31:0] tot;
  int          fails;
  int          compares;
  field_model fm (.i_mclk(i_mclk), .o_field(fld));
  event_freq_counter uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_wr(i_wr), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_int_global(i_int_global), .i_gate_enable_input(fld.gate),
    .i_event_signal_input(fld.evt), .i_aux_input(fld.aux), .o_out_pin(o_out_pin), .o_irq(o_irq),
    .o_count(o_count), .o_ctrl(o_ctrl));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // counts wrap at the limit, so a count cleared by the trigger never shows the limit itself
  function automatic logic [31:0] exp_cnt(input logic [31:0] n, input logic [31:0] a);
    return n % a;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    // look off the launching edge so registered outputs have settled
    #2;
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    #1;
    i_wr      = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
    @(posedge i_mclk);
    #1;
    i_wr = 1'b0;
  endtask
  task automatic print_verdict;
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_mclk);
    fails++;
    print_verdict();
  end
  initial begin
    i_reset = 1'b1;
    i_wr = 1'b0;
    i_wr_addr = 8'h00;
    i_wr_data = 32'h0;
    i_int_global = 1'b1;
    seed = 32'ha72a;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    chk("pin idle", 32'h1, {31'h0, o_out_pin});
    lim = 32'h3 + {30'h0, seed[1:0]};
    wr(OFS_CTRL, 32'h808c);
    wr(OFS_CONST_A, lim);
    chk("const load", lim, o_count);
    wr(OFS_TRIG_EVT, 32'h0);
    fm.evt(int'(lim) - 1, 6);
    repeat (8) @(posedge i_mclk);
    chk("count below limit", lim - 32'h1, o_count);
    // matches must lie more than one pulse length apart, or pulses merge
    fm.evt(1, 6);
    chk("count wrapped", 32'h0, o_count);
    chk("pulse active", 32'h1, {31'h0, o_out_pin});
    chk("irq on match", 32'h1, {31'h0, o_irq});
    repeat (70) @(posedge i_mclk);
    chk("pulse ended", 32'h0, {31'h0, o_out_pin});
    wr(OFS_STATUS, 32'h1);
    chk("irq status clear", 32'h0, {31'h0, o_irq});
    tot = 32'h0;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      fm.evt(int'(seed[2:0]) + 1, 8);
      tot = tot + {29'h0, seed[2:0]} + 32'h1;
      repeat (8) @(posedge i_mclk);
      chk("random events", exp_cnt(tot, lim), o_count);
    end
    fm.evt(int'(lim), 8);
    repeat (8) @(posedge i_mclk);
    chk("irq after match", 32'h1, {31'h0, o_irq});
    wr(OFS_CTRL, 32'h009c);
    chk("irq enable clear", 32'h0, {31'h0, o_irq});
    tot = exp_cnt(tot, lim);
    fm.lvl(1'b1, 1'b0);
    fm.evt(2, 5);
    repeat (8) @(posedge i_mclk);
    chk("gated off", tot, o_count);
    fm.lvl(1'b0, 1'b1);
    wr(OFS_CTRL, 32'h038c);
    fm.evt(int'(tot) + 2, 5);
    repeat (8) @(posedge i_mclk);
    chk("down holds zero", 32'h0, o_count);
    fm.lvl(1'b0, 1'b0);
    fm.evt(1, 5);
    repeat (8) @(posedge i_mclk);
    chk("up count", 32'h1, o_count);
    wr(OFS_CTRL, 32'h208c);
    fm.evt(1, 40);
    chk("short pulse rejected", 32'h1, o_count);
    fm.evt(1, 110);
    chk("long pulse taken", 32'h2, o_count);
    wr(OFS_CTRL, 32'h9cac);
    wr(OFS_TRIG, 32'h0);
    fm.evt(2, 5);
    fm.lvl(1'b1, 1'b0);
    repeat (8) @(posedge i_mclk);
    seed = lfsr(seed);
    fm.evt(int'(seed[2:0]) + 2, 5);
    fm.lvl(1'b0, 1'b0);
    repeat (8) @(posedge i_mclk);
    chk("frequency count", {29'h0, seed[2:0]} + 32'h2, o_count);
    chk("freq irq", 32'h1, {31'h0, o_irq});
    chk("freq pulse", 32'h1, {31'h0, o_out_pin});
    wr(OFS_CTRL, 32'h408c);
    wr(OFS_CONST_A, 32'h00012345);
    chk("wide load", 32'h00012345, o_count);
    print_verdict();
  end
endmodule
bind event_freq_counter event_freq_counter_monitor mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_wr(i_wr),
  .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_int_global(i_int_global),
  .i_gate_enable_input(i_gate_enable_input), .i_event_signal_input(i_event_signal_input),
  .i_aux_input(i_aux_input), .o_out_pin(o_out_pin), .o_irq(o_irq), .o_count(o_count), .o_ctrl(o_ctrl));
